// ==== design/spm_pin_mux.sv ====
/*
 Pin mux for the three async serial port pins, with APB registers.
 Assumes pins resolved outside from out, oe_n and keeper enable,
 and a serial port that supplies transmit data and its clock source.
 Holds control, direction and output data registers, a read-only
 status word, the per-pin drive and keeper state, and the input
 sampling that feeds the receiver and the external clock path.
 Assumes stop_mode is already synchronous to ref_clk and that the
 pad keeps the level on pin_out while pin_keep is high.
*/
`timescale 1ns/1ps
`include "spm_defs.svh"

module spm_pin_mux #(
    parameter int NPINS = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SPM_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_mode,
    input wire logic [NPINS-1:0] pin_in,
    output logic [NPINS-1:0] pin_out,
    output logic [NPINS-1:0] pin_oe_n,
    output logic [NPINS-1:0] pin_keep,
    input wire logic ser_txd,
    input wire logic ser_sclk_out,
    input wire logic ser_sclk_drive,
    output logic ser_rxd,
    output logic ser_sclk_in
);

    if (NPINS != 3) begin : g_bad_npins
        $error("spm_pin_mux serves exactly three pins");
    end

    // Role bits and status fields must fit the pins and the data word
    if (`SPM_BIT_RX >= NPINS || `SPM_BIT_TX >= NPINS
        || `SPM_BIT_CLK >= NPINS) begin : g_bad_bits
        $error("spm_pin_mux pin roles exceed the pin count");
    end
    if (`SPM_STAT_KEEP_LSB < `SPM_STAT_DRIVE_LSB + NPINS
        || `SPM_STAT_STOP_BIT < `SPM_STAT_KEEP_LSB + NPINS
        || `SPM_STAT_STOP_BIT > 31) begin : g_bad_stat
        $error("spm_pin_mux status fields overlap");
    end
    if ($bits(`SPM_CTL_RST) != NPINS || $bits(`SPM_DIR_RST) != NPINS
        || $bits(`SPM_DAT_RST) != NPINS) begin : g_bad_rst
        $error("spm_pin_mux reset values do not match the pin count");
    end
    if (`SPM_ADDR_W < 4 || `SPM_ADDR_W > 32) begin : g_bad_addr
        $error("spm_pin_mux address width out of range");
    end

    logic [NPINS-1:0] ctl_q, ctl_d;
    logic [NPINS-1:0] dir_q, dir_d;
    logic [NPINS-1:0] dat_q, dat_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic [NPINS-1:0] drive_q, drive_d;
    logic [NPINS-1:0] out_q, out_d;
    logic [NPINS-1:0] oe_n_q, oe_n_d;
    logic [NPINS-1:0] keep_q, keep_d;
    logic [NPINS-1:0] in_q, in_d;
    logic stop_q, stop_d;
    logic setup;
    logic access;
    logic mapped;
    logic hit_ctl;
    logic hit_dir;
    logic hit_dat;
    logic hit_stat;
    logic [NPINS-1:0] ser_drive, ser_out;
    logic [31:0] stat_word;
    spm_pkg::spm_role_t role [NPINS];

    assign setup = psel & ~penable;
    assign access = psel & penable;

    always_comb begin
        hit_ctl = 1'b0;
        hit_dir = 1'b0;
        hit_dat = 1'b0;
        hit_stat = 1'b0;
        // Full-width compare, so aliases of a register answer as unmapped
        case (paddr)
            `SPM_OFF_CTL: hit_ctl = 1'b1;
            `SPM_OFF_DIR: hit_dir = 1'b1;
            `SPM_OFF_DAT: hit_dat = 1'b1;
            `SPM_OFF_STAT: hit_stat = 1'b1;
            default: ;
        endcase
        mapped = hit_ctl | hit_dir | hit_dat | hit_stat;
    end

    // Register file; stat is read-only
    always_comb begin
        ctl_d = ctl_q;
        dir_d = dir_q;
        dat_d = dat_q;
        if (access && pwrite) begin
            if (hit_ctl) begin
                ctl_d = pwdata[NPINS-1:0];
            end
            if (hit_dir) begin
                dir_d = pwdata[NPINS-1:0];
            end
            if (hit_dat) begin
                dat_d = pwdata[NPINS-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `SPM_CTL_RST;
            dir_q <= `SPM_DIR_RST;
            dat_q <= `SPM_DAT_RST;
        end else begin
            ctl_q <= ctl_d;
            dir_q <= dir_d;
            dat_q <= dat_d;
        end
    end

    // Status word: drive, keeper and stop state as seen by the pins
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[`SPM_STAT_DRIVE_LSB +: NPINS] = drive_q;
        stat_word[`SPM_STAT_KEEP_LSB +: NPINS] = keep_q;
        stat_word[`SPM_STAT_STOP_BIT] = stop_q;
    end

    // Read data captured in setup so the access phase needs no wait
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            err_d = ~mapped;
            if (hit_ctl) begin
                rdata_d[NPINS-1:0] = ctl_q;
            end
            if (hit_dir) begin
                rdata_d[NPINS-1:0] = dir_q;
            end
            if (hit_dat) begin
                rdata_d[NPINS-1:0] = in_q;
            end
            if (hit_stat) begin
                rdata_d = stat_word;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = access;
    assign pslverr = access & err_q;

    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            role[i] = ctl_q[i] ? spm_pkg::SPM_ROLE_SERIAL
                               : spm_pkg::SPM_ROLE_GPIO;
        end
    end

    // Inputs frozen in stop so nothing sees a floating pin
    always_comb begin
        stop_d = stop_mode;
        if (stop_mode) begin
            in_d = in_q;
        end else begin
            in_d = pin_in;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= 1'b0;
            in_q <= '0;
        end else begin
            stop_q <= stop_d;
            in_q <= in_d;
        end
    end

    // Direction and level that the serial function asks of each pin
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            case (i)
                `SPM_BIT_RX: begin
                    ser_drive[i] = 1'b0;
                    ser_out[i] = 1'b0;
                end
                `SPM_BIT_TX: begin
                    ser_drive[i] = 1'b1;
                    ser_out[i] = ser_txd;
                end
                // Clock direction follows the port's clock source
                `SPM_BIT_CLK: begin
                    ser_drive[i] = ser_sclk_drive;
                    ser_out[i] = ser_sclk_out;
                end
                default: begin
                    ser_drive[i] = 1'b0;
                    ser_out[i] = 1'b0;
                end
            endcase
        end
    end

    // Pin drive; no wait input exists, so wait cannot disturb pins
    always_comb begin
        drive_d = drive_q;
        out_d = out_q;
        for (int i = 0; i < NPINS; i++) begin
            case (role[i])
                spm_pkg::SPM_ROLE_GPIO: begin
                    drive_d[i] = dir_q[i];
                    out_d[i] = dat_q[i];
                end
                spm_pkg::SPM_ROLE_SERIAL: begin
                    drive_d[i] = ser_drive[i];
                    out_d[i] = ser_out[i];
                end
                default: begin
                    drive_d[i] = 1'b0;
                    out_d[i] = 1'b0;
                end
            endcase
        end
        if (stop_mode) begin
            // Freeze last state so the keeper holds what was driven
            drive_d = drive_q;
            out_d = out_q;
        end
        oe_n_d = stop_mode ? {NPINS{1'b1}} : ~drive_d;
        keep_d = stop_mode ? drive_d : {NPINS{1'b0}};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_q <= '0;
            out_q <= '0;
            oe_n_q <= '1;
            keep_q <= '0;
        end else begin
            drive_q <= drive_d;
            out_q <= out_d;
            oe_n_q <= oe_n_d;
            keep_q <= keep_d;
        end
    end

    assign pin_out = out_q;
    assign pin_oe_n = oe_n_q;
    assign pin_keep = keep_q;

    // Idle-high line to the receiver while not selected or in stop
    always_comb begin
        if (ctl_q[`SPM_BIT_RX] && !stop_q) begin
            ser_rxd = in_q[`SPM_BIT_RX];
        end else begin
            ser_rxd = 1'b1;
        end
    end

    // Clock from the pin only when the port does not drive it
    always_comb begin
        if (ctl_q[`SPM_BIT_CLK] && !ser_sclk_drive && !stop_q) begin
            ser_sclk_in = in_q[`SPM_BIT_CLK];
        end else begin
            ser_sclk_in = 1'b0;
        end
    end

endmodule

// ==== common/spm_defs.svh ====
/*
 Offsets, field positions and reset values of the serial port pin mux.
 Assumes a 32-bit APB register bus with byte addresses.
*/
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

`define SPM_ADDR_W 12
`define SPM_OFF_CTL 12'h000
`define SPM_OFF_DIR 12'h004
`define SPM_OFF_DAT 12'h008
`define SPM_OFF_STAT 12'h00C

`define SPM_BIT_RX 0
`define SPM_BIT_TX 1
`define SPM_BIT_CLK 2

`define SPM_CTL_RST 3'h0
`define SPM_DIR_RST 3'h0
`define SPM_DAT_RST 3'h0

`define SPM_STAT_DRIVE_LSB 0
`define SPM_STAT_KEEP_LSB 3
`define SPM_STAT_STOP_BIT 6

`endif

// ==== common/spm_pkg.sv ====
/*
 Types of the serial port pin mux.
 Assumes nothing of its surroundings.
*/
package spm_pkg;
    typedef enum logic [1:0] {
        SPM_ROLE_GPIO = 2'b01,
        SPM_ROLE_SERIAL = 2'b10
    } spm_role_t;
endpackage

// ==== tb/spm_peer.sv ====
/* Serial peer and pin wires.
 Assumes the mux's out, oe_n, keep. */
`timescale 1ns/1ps
module spm_peer (
    input wire logic [2:0] pin_out,
    input wire logic [2:0] pin_oe_n,
    input wire logic [2:0] pin_keep,
    input wire logic [2:0] peer_val,
    output logic [2:0] pin_in
);
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            // Peer drives any pin that the mux neither drives nor keeps
            pin_in[i] = peer_val[i];
            if (!pin_oe_n[i] || pin_keep[i])
                pin_in[i] = pin_out[i];
        end
    end
endmodule

// ==== tb/spm_pin_mux_props.sv ====
/* Checker of the pin mux pin ports.
 Assumes binding to spm_pin_mux. */
`timescale 1ns/1ps
module spm_pin_mux_props #(
    parameter int NPINS = 3
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic stop_mode,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic [NPINS-1:0] pin_oe_n,
    input wire logic [NPINS-1:0] pin_keep,
    input wire logic ser_rxd,
    input wire logic ser_sclk_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rst; !$past(rst_n) |-> pin_oe_n == '1 && ser_rxd; endproperty
    a_rst: assert property (p_rst) else $error("pin driven at reset");
    property p_off; stop_mode |=> pin_oe_n == '1; endproperty
    a_off: assert property (p_off) else $error("driver on in stop");
    property p_kp;
        $rose(stop_mode) |=> pin_keep == ~$past(pin_oe_n);
    endproperty
    a_kp: assert property (p_kp) else $error("keeper mismatch");
    property p_hold; stop_mode |=> $stable(pin_out); endproperty
    a_hold: assert property (p_hold) else $error("level moved in stop");
    property p_exc; (pin_keep & ~pin_oe_n) == '0; endproperty
    a_exc: assert property (p_exc) else $error("keeper while driving");
    property p_run; !stop_mode |=> pin_keep == '0; endproperty
    a_run: assert property (p_run) else $error("keeper out of stop");
    property p_rx; stop_mode [*2] |-> ser_rxd; endproperty
    a_rx: assert property (p_rx) else $error("rx used in stop");
    property p_ck; stop_mode [*2] |-> !ser_sclk_in; endproperty
    a_ck: assert property (p_ck) else $error("clock used in stop");
endmodule
bind spm_pin_mux spm_pin_mux_props #(.NPINS(NPINS)) i_props (.ref_clk,
    .rst_n, .stop_mode, .pin_out, .pin_oe_n, .pin_keep, .ser_rxd,
    .ser_sclk_in);

// ==== tb/serial_port_pin_mux_test.sv ====
/* Bench of the serial port pin mux.
 Assumes the mux, its checker and the peer model. */
`timescale 1ns/1ps
`include "spm_defs.svh"
module serial_port_pin_mux_test;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic pready, pslverr, stop_mode = 0, txd = 0, sck = 0, drv = 0, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [2:0] pin_in, pin_out, pin_oe_n, pin_keep, pv = '0;
    logic ser_rxd, ser_sclk_in;
    int num_errors = 0, n_tests = 0;
    typedef struct {logic [2:0] c, d, v; logic t, r;
        logic [2:0] oe, o;} spm_row_t;
    spm_row_t rows [5] = '{'{3'h0, 3'h7, 3'h5, 1'h0, 1'h0, 3'h0, 3'h5},
        '{3'h0, 3'h2, 3'h7, 1'h0, 1'h0, 3'h5, 3'h2},
        '{3'h7, 3'h0, 3'h0, 1'h1, 1'h1, 3'h1, 3'h2},
        '{3'h7, 3'h7, 3'h0, 1'h0, 1'h0, 3'h5, 3'h0},
        '{3'h5, 3'h2, 3'h0, 1'h0, 1'h1, 3'h1, 3'h4}};
    spm_pin_mux i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .stop_mode, .pin_in, .pin_out,
        .pin_oe_n, .pin_keep, .ser_txd(txd), .ser_sclk_out(sck),
        .ser_sclk_drive(drv), .ser_rxd, .ser_sclk_in);
    spm_peer i_peer (.pin_out, .pin_oe_n, .pin_keep, .peer_val(pv), .pin_in);
    always #12.5 ref_clk = ~ref_clk;
    task automatic print_verdict;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_tests++;
        if (g !== x) begin
            num_errors++;
            $display("Error %0t: got %0h want %0h", $time, g, x);
        end
    endtask
    // Called just after a rising edge; one idle edge after release
    task automatic xf(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int i;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        for (i = 0; i < 9; i++) begin
            @(posedge ref_clk);
            if (pready === 1'h1)
                break;
        end
        if (i == 9) begin
            num_errors++;
            print_verdict();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge ref_clk);
    endtask
    task automatic w2;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'h1;
        pv <= 3'h4;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            xf(1'h1, `SPM_OFF_CTL, rows[i].c);
            xf(1'h1, `SPM_OFF_DIR, rows[i].d);
            xf(1'h1, `SPM_OFF_DAT, rows[i].v);
            txd <= rows[i].t;
            sck <= ~rows[i].t;
            drv <= rows[i].r;
            w2();
            chk(pin_oe_n, rows[i].oe);
            chk(pin_out & ~pin_oe_n, rows[i].o);
            chk(ser_rxd, rows[i].c[0] ? pv[0] : 1'h1);
            chk(ser_sclk_in,
                (rows[i].c[2] && !rows[i].r) ? pv[2] : 1'h0);
            $display("row %0d done", i);
            @(posedge ref_clk);
        end
        xf(1'h0, 12'h010, '0);
        chk(e, 1'h1);
        chk(q, '0);
        xf(1'h1, `SPM_OFF_CTL, '0);
        xf(1'h1, `SPM_OFF_DIR, 3'h2);
        xf(1'h1, `SPM_OFF_DAT, 3'h2);
        pv <= 3'h1;
        repeat (2) @(posedge ref_clk);
        stop_mode <= 1'h1;
        // Peer moves while stopped; readback must stay old
        pv <= 3'h4;
        w2();
        chk(pin_oe_n, 3'h7);
        chk(pin_keep, 3'h2);
        chk(pin_out[1], 1'h1);
        chk(ser_rxd, 1'h1);
        @(posedge ref_clk);
        xf(1'h0, `SPM_OFF_DAT, '0);
        chk(q, 3'h3);
        stop_mode <= 1'h0;
        w2();
        chk(pin_oe_n, 3'h5);
        $display("stop done");
        @(posedge ref_clk);
        rst_n <= 1'h0;
        w2();
        rst_n <= 1'h1;
        w2();
        chk(pin_oe_n, 3'h7);
        chk(ser_sclk_in, 1'h0);
        @(posedge ref_clk);
        xf(1'h0, `SPM_OFF_CTL, '0);
        chk(q, '0);
        xf(1'h0, `SPM_OFF_DIR, '0);
        chk(q, '0);
        $display("reset done");
        print_verdict();
    end
endmodule
